// *** dv/echo_canceller_monitor_status_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module echo_canceller_monitor_status_chk (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Core side
	input wire logic [4:0]  monitored_channel_select,
	input wire logic        irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_write_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	sequence s_read_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	a_write_answer: assert property (s_write_take |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	a_write_ready_low: assert property (s_write_take |=> !s_axi_awready && !s_axi_wready)
		else $error("write ready not dropped");
	a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	a_read_answer: assert property (s_read_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data missing");
	a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read data not released");
	a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:13] == 19'h0)
		else $error("read data upper bits set");
	a_channel_only_write: assert property (!$rose(s_axi_bvalid) |-> $stable(monitored_channel_select))
		else $error("channel changed without write");
	// Explicit disable: the reset itself is the cause here
	a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !irq && !s_axi_bvalid
		&& !s_axi_rvalid && monitored_channel_select == 5'h00)
		else $error("outputs not cleared by reset");
endmodule

bind echo_canceller_monitor_status echo_canceller_monitor_status_chk i_chk (.*);

`default_nettype wire

// *** dv/echo_canceller_monitor_status_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module echo_canceller_monitor_status_tb;
	logic                                 aclk = 1'b0;
	logic                                 aresetn = 1'b0;
	logic [11:0]                          s_axi_awaddr = 12'h000;
	logic                                 s_axi_awvalid = 1'b0;
	logic                                 s_axi_awready;
	logic [31:0]                          s_axi_wdata = 32'h0000_0000;
	logic [3:0]                           s_axi_wstrb = 4'h0;
	logic                                 s_axi_wvalid = 1'b0;
	logic                                 s_axi_wready;
	logic [1:0]                           s_axi_bresp;
	logic                                 s_axi_bvalid;
	logic                                 s_axi_bready = 1'b0;
	logic [11:0]                          s_axi_araddr = 12'h000;
	logic                                 s_axi_arvalid = 1'b0;
	logic                                 s_axi_arready;
	logic [31:0]                          s_axi_rdata;
	logic [1:0]                           s_axi_rresp;
	logic                                 s_axi_rvalid;
	logic                                 s_axi_rready = 1'b0;
	monitor_bank_pkg::monitor_sample_type monitor_sample = '0;
	logic                                 monitor_sample_valid = 1'b0;
	logic [4:0]                           monitored_channel_select;
	logic [4:0]                           bypass_threshold;
	logic                                 monitor_pin_one;
	logic                                 monitor_pin_two;
	logic                                 irq;
	int                                   miscompares = 0;
	int                                   compares = 0;
	// Byte addresses: nlp, overcomp, word one..three, control, pin config, status, mask
	localparam logic [11:0] adr [9] = '{12'h09C, 12'h0A0, 12'h0B0, 12'h0B4, 12'h0B8,
		12'h0C0, 12'h0C4, 12'h0C8, 12'h0CC};
	localparam logic [7:0] w2 = 8'h7E;

	echo_canceller_monitor_status i_echo_canceller_monitor_status (.*);

	always #20 aclk = ~aclk;

	task automatic tally_and_finish;
		if (miscompares == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_up(input string what);
		check(what, 32'h1, 32'h0);
		tally_and_finish();
	endtask

	task automatic bus_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		if (s_axi_bvalid !== 1'b1)
			give_up("bvalid");
		s_axi_bready <= 1'b0;
		check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask

	task automatic expect_reg(input string what, input logic [11:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		if (s_axi_rvalid !== 1'b1)
			give_up("rvalid");
		s_axi_rready <= 1'b0;
		check(what, exp, s_axi_rdata);
		check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask

	task automatic push_sample(input monitor_bank_pkg::monitor_sample_type v);
		@(posedge aclk);
		monitor_sample       <= v;
		monitor_sample_valid <= 1'b1;
		@(posedge aclk);
		monitor_sample_valid <= 1'b0;
	endtask

	task automatic expect_words(input logic [39:0] e);
		expect_reg("nlp level", adr[0], {24'h0, e[39:32]}, 2'h0);
		expect_reg("overcomp hang", adr[1], {24'h0, e[31:24]}, 2'h0);
		expect_reg("word one", adr[2], {24'h0, e[23:16]}, 2'h0);
		expect_reg("word two", adr[3], {24'h0, e[15:8]}, 2'h0);
		expect_reg("word three", adr[4], {24'h0, e[7:0]}, 2'h0);
	endtask

	task automatic t_reset_values;
		for (int i = 0; i < 9; i++)
			expect_reg("reset value", adr[i], 32'h0000_0000, 2'h0);
		check("irq", 32'h0, {31'h0, irq});
	endtask

	task automatic t_capture;
		monitor_bank_pkg::monitor_sample_type v;
		v = '0;
		v.nonlinear_threshold_level = 8'h80;
		v.overcomp_hang.overcomp_evaluation = 4'h9;
		v.overcomp_hang.doubletalk_hangover_time = 4'h2;
		v.state_one.no_voice_flag = 1'b1;
		v.state_one.canceller_bypass_flag = 1'b1;
		v.state_two.subtractor_bypass_flag = 1'b1;
		v.state_two.silent_channel_flag = 1'b1;
		v.state_three.timeslot_signalling_disable_flag = 1'b1;
		v.state_three.serial_flexible_control_flag = 1'b1;
		push_sample(v);
		expect_words(40'h80_9281_8181);
		// Top code of the log scale is the ceiling
		push_sample({8'hFF, 8'h5A, 8'h7E, w2, 8'h7E});
		expect_words({8'hBF, 8'h5A, 8'h7E, w2, 8'h7E});
	endtask

	task automatic t_readonly;
		for (int i = 0; i < 5; i++)
			bus_write(adr[i], 32'hFFFF_FFFF, 4'hF, 2'h0);
		expect_words({8'hBF, 8'h5A, 8'h7E, w2, 8'h7E});
		bus_write(12'h400, 32'h0000_0001, 4'hF, 2'h2);
		bus_write(12'h0A4, 32'h0000_0001, 4'hF, 2'h2);
		expect_reg("unmapped", 12'h800, 32'h0000_0000, 2'h2);
	endtask

	task automatic t_control;
		bus_write(adr[5], 32'h0000_1F15, 4'hF, 2'h0);
		check("channel", 32'h15, {27'h0, monitored_channel_select});
		check("threshold", 32'h1F, {27'h0, bypass_threshold});
		// Lane 0 only: threshold must keep its value
		bus_write(adr[5], 32'h0000_0A0A, 4'h1, 2'h0);
		expect_reg("control", adr[5], 32'h0000_1F0A, 2'h0);
		check("channel", 32'h0A, {27'h0, monitored_channel_select});
	endtask

	task automatic t_pins;
		for (int b = 0; b < 8; b++) begin
			bus_write(adr[6], {24'h0, 1'b1, 3'(7 - b), 1'b1, 3'(b)}, 4'hF, 2'h0);
			repeat (2) @(posedge aclk);
			check("pin one", {31'h0, w2[b]}, {31'h0, monitor_pin_one});
			check("pin two", {31'h0, w2[7 - b]}, {31'h0, monitor_pin_two});
		end
		bus_write(adr[6], 32'h0000_0071, 4'hF, 2'h0);
		repeat (2) @(posedge aclk);
		check("pins off", 32'h0, {30'h0, monitor_pin_two, monitor_pin_one});
	endtask

	task automatic t_irq;
		expect_reg("irq status", adr[7], 32'h0000_0003, 2'h0);
		check("irq masked", 32'h0, {31'h0, irq});
		bus_write(adr[8], 32'h0000_0001, 4'hF, 2'h0);
		repeat (2) @(posedge aclk);
		check("irq on", 32'h1, {31'h0, irq});
		bus_write(adr[7], 32'h0000_0001, 4'hF, 2'h0);
		repeat (2) @(posedge aclk);
		check("irq cleared", 32'h0, {31'h0, irq});
		expect_reg("irq status", adr[7], 32'h0000_0002, 2'h0);
		bus_write(adr[7], 32'h0000_0002, 4'hF, 2'h0);
		push_sample('0);
		repeat (2) @(posedge aclk);
		check("irq update", 32'h1, {31'h0, irq});
		expect_reg("irq status", adr[7], 32'h0000_0001, 2'h0);
	endtask

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset_values();
		t_capture();
		t_readonly();
		t_control();
		t_pins();
		t_irq();
		tally_and_finish();
	end
endmodule

`default_nettype wire

// *** hdl/echo_canceller_monitor_status.sv ***
// Contract
// - The nonlinear threshold level of the selected channel is reported as an 8-bit log code at index 27H.
// - Index 28H holds the 4-bit overcompensation evaluation in bits 7:4 and the 4-bit hang-over time in bits 3:0.
// - State word one at 2CH shows no-voice in bit 7 and the three 2100Hz answer-tone detections in bits 6:4.
// - State word one bit 3 shows the filter store being cleared and bit 2 the store held.
// - State word one bit 1 shows the nonlinear processor active and bit 0 the whole canceller bypassed.
// - Single bits of state word two at 2DH can be routed to either of two monitor pins by a config register.
// - State word two bit 7 shows the subtractor bypassed because echo return loss exceeds the 5-bit threshold.
// - State word two bit 6 shows true double talk.
// - State word two bit 5 shows fast convergence and bit 4 convergence protection for non-speech.
// - State word two bits 3:1 show the 2010Hz tone unprotected, second level reached and first level reached.
// - State word two bit 0 shows an idle channel.
// - State word three at 2EH bit 7 shows the channel disabled by timeslot signalling evaluation.
// - State word three bit 6 shows the control channel disable bit and bit 5 its fixed-function bit.
// - State word three bits 4:0 mirror the serial disable, processor off, hold, adapt off and flexible inputs.
// - Log values use a scale where 191 is 3 dBm0 and 16 codes equal 6 dB.
`timescale 1ns/1ps
`default_nettype none

module echo_canceller_monitor_status (
	// Clock and reset
	input  wire logic                                      aclk,
	input  wire logic                                      aresetn,
	// Write address channel
	input  wire logic [monitor_bank_pkg::ADDR_W-1:0]       s_axi_awaddr,
	input  wire logic                                      s_axi_awvalid,
	output logic                                           s_axi_awready,
	// Write data channel
	input  wire logic [monitor_bank_pkg::DATA_W-1:0]       s_axi_wdata,
	input  wire logic [monitor_bank_pkg::DATA_W/8-1:0]     s_axi_wstrb,
	input  wire logic                                      s_axi_wvalid,
	output logic                                           s_axi_wready,
	// Write response channel
	output logic [1:0]                                     s_axi_bresp,
	output logic                                           s_axi_bvalid,
	input  wire logic                                      s_axi_bready,
	// Read address channel
	input  wire logic [monitor_bank_pkg::ADDR_W-1:0]       s_axi_araddr,
	input  wire logic                                      s_axi_arvalid,
	output logic                                           s_axi_arready,
	// Read data channel
	output logic [monitor_bank_pkg::DATA_W-1:0]            s_axi_rdata,
	output logic [1:0]                                     s_axi_rresp,
	output logic                                           s_axi_rvalid,
	input  wire logic                                      s_axi_rready,
	// Monitor snapshot from the canceller core
	input  wire monitor_bank_pkg::monitor_sample_type      monitor_sample,
	input  wire logic                                      monitor_sample_valid,
	// Settings driven into the core
	output logic [monitor_bank_pkg::CHANNEL_W-1:0]         monitored_channel_select,
	output logic [monitor_bank_pkg::THRESHOLD_W-1:0]       bypass_threshold,
	// Monitor pins and interrupt
	output logic                                           monitor_pin_one,
	output logic                                           monitor_pin_two,
	output logic                                           irq
);

	// Snapshot registers
	monitor_bank_pkg::monitor_sample_type monitor_r;

	// Software registers
	logic [monitor_bank_pkg::CHANNEL_W-1:0]   channel_r;
	logic [monitor_bank_pkg::THRESHOLD_W-1:0] threshold_r;
	logic [7:0]                               pin_config_r;
	logic [monitor_bank_pkg::IRQ_W-1:0]       irq_status_r;
	logic [monitor_bank_pkg::IRQ_W-1:0]       irq_status_nxt;
	logic [monitor_bank_pkg::IRQ_W-1:0]       irq_mask_r;
	logic                                     irq_r;
	logic [monitor_bank_pkg::PIN_COUNT-1:0]   pin_r;

	// Bus state
	logic                                     aw_free_r;
	logic                                     w_free_r;
	logic [monitor_bank_pkg::ADDR_W-1:0]      awaddr_r;
	logic [monitor_bank_pkg::DATA_W-1:0]      wdata_r;
	logic [monitor_bank_pkg::DATA_W/8-1:0]    wstrb_r;
	logic                                     bvalid_r;
	logic [1:0]                               bresp_r;
	logic                                     arready_r;
	logic                                     rvalid_r;
	logic [monitor_bank_pkg::DATA_W-1:0]      rdata_r;
	logic [1:0]                               rresp_r;

	// Decode wires
	wire logic       aw_take  = s_axi_awvalid & aw_free_r;
	wire logic       w_take   = s_axi_wvalid & w_free_r;
	wire logic       wr_fire  = ~aw_free_r & ~w_free_r & ~bvalid_r;
	wire logic       ar_take  = s_axi_arvalid & arready_r;
	wire logic [7:0] wr_idx   = awaddr_r[9:2];
	wire logic [7:0] rd_idx   = s_axi_araddr[9:2];
	wire logic       wr_upper = |awaddr_r[monitor_bank_pkg::ADDR_W-1:10];
	wire logic       rd_upper = |s_axi_araddr[monitor_bank_pkg::ADDR_W-1:10];

	wire logic wr_control = wr_fire & ~wr_upper & (wr_idx == monitor_bank_pkg::IDX_CONTROL);
	wire logic wr_pin_cfg = wr_fire & ~wr_upper & (wr_idx == monitor_bank_pkg::IDX_PIN_CONFIG);
	wire logic wr_irq_sts = wr_fire & ~wr_upper & (wr_idx == monitor_bank_pkg::IDX_IRQ_STATUS);
	wire logic wr_irq_msk = wr_fire & ~wr_upper & (wr_idx == monitor_bank_pkg::IDX_IRQ_MASK);

	// Monitor words are read-only, so a write there is accepted and dropped
	wire logic wr_monitor = ~wr_upper & (
		(wr_idx == monitor_bank_pkg::IDX_NLP_THRESHOLD) |
		(wr_idx == monitor_bank_pkg::IDX_OVERCOMP_HANG) |
		(wr_idx == monitor_bank_pkg::IDX_STATE_ONE) |
		(wr_idx == monitor_bank_pkg::IDX_STATE_TWO) |
		(wr_idx == monitor_bank_pkg::IDX_STATE_THREE));
	wire logic wr_known = wr_monitor | (~wr_upper & (
		(wr_idx == monitor_bank_pkg::IDX_CONTROL) |
		(wr_idx == monitor_bank_pkg::IDX_PIN_CONFIG) |
		(wr_idx == monitor_bank_pkg::IDX_IRQ_STATUS) |
		(wr_idx == monitor_bank_pkg::IDX_IRQ_MASK)));

	// Software clear of interrupt bits, byte lane zero only
	wire logic [monitor_bank_pkg::IRQ_W-1:0] irq_clear =
		(wr_irq_sts & wstrb_r[0]) ? wdata_r[monitor_bank_pkg::IRQ_W-1:0] : '0;

	// Overrun flags a snapshot that lands before software cleared the last one
	logic [monitor_bank_pkg::IRQ_W-1:0] irq_set;

	// Bits placed by name so a new event cannot shift the layout
	always_comb begin
		irq_set = '0;
		irq_set[monitor_bank_pkg::IRQ_UPDATE_BIT]  = monitor_sample_valid;
		irq_set[monitor_bank_pkg::IRQ_OVERRUN_BIT] = monitor_sample_valid &
			irq_status_r[monitor_bank_pkg::IRQ_UPDATE_BIT];
	end

	// Codes above the top of the log scale are held at the top code
	wire logic [7:0] threshold_code =
		(monitor_sample.nonlinear_threshold_level > monitor_bank_pkg::LOG_MAX_CODE) ?
		monitor_bank_pkg::LOG_MAX_CODE : monitor_sample.nonlinear_threshold_level;

	wire logic [7:0] state_two_bits = monitor_r.state_two;

	// Read hits, one per register index
	wire logic rd_nlp    = rd_idx == monitor_bank_pkg::IDX_NLP_THRESHOLD;
	wire logic rd_ocdt   = rd_idx == monitor_bank_pkg::IDX_OVERCOMP_HANG;
	wire logic rd_one    = rd_idx == monitor_bank_pkg::IDX_STATE_ONE;
	wire logic rd_two    = rd_idx == monitor_bank_pkg::IDX_STATE_TWO;
	wire logic rd_three  = rd_idx == monitor_bank_pkg::IDX_STATE_THREE;
	wire logic rd_ctrl   = rd_idx == monitor_bank_pkg::IDX_CONTROL;
	wire logic rd_pincfg = rd_idx == monitor_bank_pkg::IDX_PIN_CONFIG;
	wire logic rd_status = rd_idx == monitor_bank_pkg::IDX_IRQ_STATUS;
	wire logic rd_mask   = rd_idx == monitor_bank_pkg::IDX_IRQ_MASK;

	// Read decode
	logic [monitor_bank_pkg::DATA_W-1:0] rd_word;
	logic                                rd_ok;

	always_comb begin
		rd_word = '0;
		rd_ok   = 1'b1;
		if (rd_upper) begin
			rd_ok = 1'b0;
		end else if (rd_nlp) begin
			rd_word[7:0] = monitor_r.nonlinear_threshold_level;
		end else if (rd_ocdt) begin
			rd_word[7:0] = monitor_r.overcomp_hang;
		end else if (rd_one) begin
			rd_word[7:0] = monitor_r.state_one;
		end else if (rd_two) begin
			rd_word[7:0] = state_two_bits;
		end else if (rd_three) begin
			rd_word[7:0] = monitor_r.state_three;
		end else if (rd_ctrl) begin
			rd_word[monitor_bank_pkg::CTRL_CHANNEL_LSB +: monitor_bank_pkg::CHANNEL_W] = channel_r;
			rd_word[monitor_bank_pkg::CTRL_THRESHOLD_LSB +: monitor_bank_pkg::THRESHOLD_W] =
				threshold_r;
		end else if (rd_pincfg) begin
			rd_word[7:0] = pin_config_r;
		end else if (rd_status) begin
			rd_word[monitor_bank_pkg::IRQ_W-1:0] = irq_status_r;
		end else if (rd_mask) begin
			rd_word[monitor_bank_pkg::IRQ_W-1:0] = irq_mask_r;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Set wins over a clear landing in the same cycle
	assign irq_status_nxt = (irq_status_r & ~irq_clear) | irq_set;

	// Write address and data are taken independently, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_free_r <= 1'b1;
			awaddr_r  <= '0;
		end else if (aw_take) begin
			aw_free_r <= 1'b0;
			awaddr_r  <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_free_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_free_r <= 1'b1;
			wdata_r  <= '0;
			wstrb_r  <= '0;
		end else if (w_take) begin
			w_free_r <= 1'b0;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_free_r <= 1'b1;
		end
	end

	// Write response one cycle after both halves are held
	// Next write stalls behind an unanswered response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= monitor_bank_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_known ? monitor_bank_pkg::RESP_OKAY : monitor_bank_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Reads have no side effect on any register
	// Arready stays low until the data is taken: one read at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= '0;
			rresp_r   <= monitor_bank_pkg::RESP_OKAY;
		end else if (ar_take) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= rd_word;
			rresp_r   <= rd_ok ? monitor_bank_pkg::RESP_OKAY : monitor_bank_pkg::RESP_SLVERR;
		end else if (rvalid_r & s_axi_rready) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	// Control register: channel select and bypass threshold
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			channel_r   <= monitor_bank_pkg::CHANNEL_RESET;
			threshold_r <= monitor_bank_pkg::THRESHOLD_RESET;
		end else begin
			if (wr_control & wstrb_r[0]) begin
				channel_r <= wdata_r[monitor_bank_pkg::CTRL_CHANNEL_LSB +:
					monitor_bank_pkg::CHANNEL_W];
			end
			if (wr_control & wstrb_r[1]) begin
				threshold_r <= wdata_r[monitor_bank_pkg::CTRL_THRESHOLD_LSB +:
					monitor_bank_pkg::THRESHOLD_W];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_config_r <= monitor_bank_pkg::PIN_CONFIG_RESET;
		end else if (wr_pin_cfg & wstrb_r[0]) begin
			pin_config_r <= wdata_r[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_r <= monitor_bank_pkg::IRQ_RESET;
		end else if (wr_irq_msk & wstrb_r[0]) begin
			irq_mask_r <= wdata_r[monitor_bank_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_r <= monitor_bank_pkg::IRQ_RESET;
			irq_r        <= 1'b0;
		end else begin
			irq_status_r <= irq_status_nxt;
			irq_r        <= |(irq_status_nxt & irq_mask_r);
		end
	end

	// Snapshot of the selected channel; the core judges the flags against the threshold
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			monitor_r <= {$bits(monitor_bank_pkg::monitor_sample_type)/8
				{monitor_bank_pkg::MONITOR_RESET}};
		end else if (monitor_sample_valid) begin
			monitor_r.nonlinear_threshold_level <= threshold_code;
			monitor_r.overcomp_hang             <= monitor_sample.overcomp_hang;
			monitor_r.state_one                 <= monitor_sample.state_one;
			monitor_r.state_two                 <= monitor_sample.state_two;
			monitor_r.state_three               <= monitor_sample.state_three;
		end
	end

	// Each pin takes one chosen bit of state word two, or stays low when disabled
	genvar p;
	generate
		for (p = 0; p < monitor_bank_pkg::PIN_COUNT; p++) begin : g_pin
			wire logic [monitor_bank_pkg::PIN_SEL_W-1:0] sel =
				pin_config_r[p*monitor_bank_pkg::PIN_FIELD_W +: monitor_bank_pkg::PIN_SEL_W];
			wire logic en =
				pin_config_r[p*monitor_bank_pkg::PIN_FIELD_W + monitor_bank_pkg::PIN_EN_OFFSET];

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pin_r[p] <= 1'b0;
				end else begin
					pin_r[p] <= en & state_two_bits[sel];
				end
			end
		end
	endgenerate

	// Outputs, every one straight from a register

	// Write channels
	assign s_axi_awready            = aw_free_r;
	assign s_axi_wready             = w_free_r;
	assign s_axi_bvalid             = bvalid_r;
	assign s_axi_bresp              = bresp_r;

	// Read channels
	assign s_axi_arready            = arready_r;
	assign s_axi_rvalid             = rvalid_r;
	assign s_axi_rdata              = rdata_r;
	assign s_axi_rresp              = rresp_r;

	// Settings towards the core
	assign monitored_channel_select = channel_r;
	assign bypass_threshold         = threshold_r;

	// Pins and interrupt
	assign monitor_pin_one          = pin_r[0];
	assign monitor_pin_two          = pin_r[1];
	assign irq                      = irq_r;

endmodule

`default_nettype wire

// *** hdl/monitor_bank_pkg.sv ***
package monitor_bank_pkg;

	// Bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_NLP_THRESHOLD = 8'h27;
	localparam logic [7:0] IDX_OVERCOMP_HANG = 8'h28;
	localparam logic [7:0] IDX_STATE_ONE     = 8'h2C;
	localparam logic [7:0] IDX_STATE_TWO     = 8'h2D;
	localparam logic [7:0] IDX_STATE_THREE   = 8'h2E;
	localparam logic [7:0] IDX_CONTROL       = 8'h30;
	localparam logic [7:0] IDX_PIN_CONFIG    = 8'h31;
	localparam logic [7:0] IDX_IRQ_STATUS    = 8'h32;
	localparam logic [7:0] IDX_IRQ_MASK      = 8'h33;

	// Control register fields
	localparam int unsigned CHANNEL_W          = 5;
	localparam int unsigned THRESHOLD_W        = 5;
	localparam int unsigned CTRL_CHANNEL_LSB   = 0;
	localparam int unsigned CTRL_THRESHOLD_LSB = 8;

	// Monitor pin configuration fields, one nibble per pin
	localparam int unsigned PIN_COUNT     = 2;
	localparam int unsigned PIN_FIELD_W   = 4;
	localparam int unsigned PIN_SEL_W     = 3;
	localparam int unsigned PIN_EN_OFFSET = 3;

	// Interrupt status and mask layout
	localparam int unsigned IRQ_W          = 2;
	localparam int unsigned IRQ_UPDATE_BIT = 0;
	localparam int unsigned IRQ_OVERRUN_BIT = 1;

	// Reset values
	localparam logic [7:0]  MONITOR_RESET    = 8'h00;
	localparam logic [CHANNEL_W-1:0] CHANNEL_RESET = 5'h00;
	localparam logic [THRESHOLD_W-1:0] THRESHOLD_RESET = 5'h00;
	localparam logic [7:0]  PIN_CONFIG_RESET = 8'h00;
	localparam logic [1:0]  IRQ_RESET        = 2'h0;

	// Logarithmic scale: top code is +3 dBm0, 16 codes per 6 dB
	localparam logic [7:0] LOG_MAX_CODE = 8'hBF;
	localparam int unsigned LOG_CODES_PER_6DB = 16;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Field positions follow declaration order, msb first
	typedef struct packed {
		logic [3:0] overcomp_evaluation;
		logic [3:0] doubletalk_hangover_time;
	} overcomp_hang_type;

	typedef struct packed {
		logic no_voice_flag;
		logic answer_tone_unprotected_flag;
		logic answer_tone_protected_flag;
		logic answer_tone_phase_reversal_flag;
		logic filter_store_clearing_flag;
		logic filter_store_held_flag;
		logic nonlinear_processor_active_flag;
		logic canceller_bypass_flag;
	} state_one_type;

	typedef struct packed {
		logic subtractor_bypass_flag;
		logic double_talk_flag;
		logic fast_convergence_flag;
		logic convergence_protection_flag;
		logic signalling_tone_unprotected_flag;
		logic signalling_tone_level_two_flag;
		logic signalling_tone_level_one_flag;
		logic silent_channel_flag;
	} state_two_type;

	typedef struct packed {
		logic timeslot_signalling_disable_flag;
		logic control_channel_disable_flag;
		logic control_channel_fixed_flag;
		logic serial_disable_flag;
		logic serial_processor_off_flag;
		logic serial_hold_flag;
		logic serial_adapt_off_flag;
		logic serial_flexible_control_flag;
	} state_three_type;

	typedef struct packed {
		logic [7:0]        nonlinear_threshold_level;
		overcomp_hang_type overcomp_hang;
		state_one_type     state_one;
		state_two_type     state_two;
		state_three_type   state_three;
	} monitor_sample_type;

endpackage
